// ==== logic/ics_exec.sv ====
// Execute stage of the integer core for branches, jumps, divide, multiply, loads and control moves.
//
// Overview of operation
// - Negative branch taken when base sign set.
// - Negative save branches write PC+8 to r31.
// - Likely branches annul delay slot when false.
// - Unequal branches taken when sources differ.
// - Debug return jumps to debug PC, leaves debug unless debug entry comes in the same cycle.
// - Signed divide: quotient low, remainder high.
// - Unsigned divide: quotient low, remainder high.
// - Exception return picks PC, clears status, link.
// - Register jumps; saving form writes PC+8.
// - Linked load sets link flag and address.
// - Upper constant load shifts immediate by 16.
// - Accumulate adds product to accumulator pair.
// - Deduct subtracts product from accumulator pair.
// - Conditional moves copy on nonzero or zero.
// - Register product writes low 32 bits.
// - Full products land in accumulator pair.
// - Or, not-or and or-immediate logic results.
// - Warm-up requests addressed line into cache.
// - Control register writes and reads via second source.
`timescale 1ns/1ns
`include "ics_regs.svh"

module ics_exec (
    input  wire logic               ref_clk,
    input  wire logic               rst,
    input  wire logic               issue_valid,
    input  wire ics_pkg::ics_op_e   op,
    input  wire ics_pkg::ics_word_t pc,
    input  wire ics_pkg::ics_word_t base_src_reg,
    input  wire ics_pkg::ics_word_t second_src_reg,
    input  wire logic [4:0]         dest_idx,
    input  wire logic [4:0]         second_idx,
    input  wire logic [15:0]        imm16,
    input  wire logic [25:0]        region_idx,
    input  wire logic [4:0]         sys_num,
    input  wire logic [2:0]         sys_sel,
    input  wire ics_pkg::ics_word_t sys_rdata,
    input  wire ics_pkg::ics_word_t ld_data,
    input  wire ics_pkg::ics_word_t status_word,
    input  wire ics_pkg::ics_word_t exc_return_pc,
    input  wire ics_pkg::ics_word_t error_return_pc,
    input  wire ics_pkg::ics_word_t debug_return_pc,
    input  wire logic               debug_enter,
    output logic                    busy_r,
    output logic                    wb_en_r,
    output logic [4:0]              wb_idx_r,
    output ics_pkg::ics_word_t      wb_data_r,
    output logic                    redirect_r,
    output ics_pkg::ics_word_t      target_r,
    output logic                    annul_r,
    output ics_pkg::ics_word_t      upper_acc_r,
    output ics_pkg::ics_word_t      bottom_acc_r,
    output logic                    link_flag_r,
    output ics_pkg::ics_word_t      link_address_r,
    output logic                    debug_mode_r,
    output logic                    status_clr_r,
    output logic                    warmup_r,
    output ics_pkg::ics_word_t      warmup_addr_r,
    output logic                    sys_wr_r,
    output logic [4:0]              sys_num_r,
    output logic [2:0]              sys_sel_r,
    output ics_pkg::ics_word_t      sys_wdata_r
);
    import ics_pkg::*;

    // True for the likely branch forms.
    function automatic logic is_likely(input ics_op_e o);
        return (o == OP_BR_NEG_LK) || (o == OP_BR_NEG_SV_LK) || (o == OP_BR_UNEQ_LK);
    endfunction

    // Branch condition of the sign and inequality branches.
    function automatic logic br_cond(input ics_op_e o, input ics_word_t a, input ics_word_t b);
        if ((o == OP_BR_UNEQ) || (o == OP_BR_UNEQ_LK)) begin
            return a != b;
        end
        return a[31];
    endfunction

    // Picks the addressed byte or half from a little-endian word and extends it.
    function automatic ics_word_t ld_ext(input ics_op_e o, input ics_word_t d, input logic [1:0] a);
        ics_word_t sh;
        sh = d >> {a, 3'b000};
        unique case (o)
            OP_LD_BYTE:  ld_ext = {{24{sh[7]}}, sh[7:0]};
            OP_LD_UBYTE: ld_ext = {24'h000000, sh[7:0]};
            OP_LD_HALF:  ld_ext = {{16{sh[15]}}, sh[15:0]};
            OP_LD_UHALF: ld_ext = {16'h0000, sh[15:0]};
            default:     ld_ext = d;
        endcase
    endfunction

    logic               accept;
    logic               take;
    logic               div_start;
    logic               div_done;
    ics_word_t          div_quot;
    ics_word_t          div_rem;
    ics_word_t          imm_sx;
    ics_word_t          eff_addr;
    ics_word_t          br_tgt;
    ics_word_t          link_pc;
    logic signed [63:0] prod_s;
    logic [63:0]        prod_u;
    logic [63:0]        acc;
    logic [63:0]        acc_new;
    logic               busy_nxt, wb_en_nxt, redirect_nxt, annul_nxt;
    logic               link_flag_nxt, debug_mode_nxt, status_clr_nxt;
    logic               warmup_nxt, sys_wr_nxt;
    logic [4:0]         wb_idx_nxt, sys_num_nxt;
    logic [2:0]         sys_sel_nxt;
    ics_word_t          wb_data_nxt, target_nxt, link_address_nxt;
    ics_word_t          warmup_addr_nxt, sys_wdata_nxt;
    ics_word_t          upper_acc_nxt, bottom_acc_nxt;

    // Operand preparation: addresses, targets and products.
    assign accept   = issue_valid & ~busy_r;
    assign take     = br_cond(op, base_src_reg, second_src_reg);
    assign imm_sx   = {{16{imm16[15]}}, imm16};
    assign eff_addr = base_src_reg + imm_sx;
    assign br_tgt   = pc + `ICS_SEQ_OFS + {imm_sx[29:0], 2'b00};
    assign link_pc  = pc + `ICS_LINK_OFS;
    assign prod_s   = $signed({{32{base_src_reg[31]}}, base_src_reg})
                    * $signed({{32{second_src_reg[31]}}, second_src_reg});
    assign prod_u   = {32'h0000_0000, base_src_reg} * {32'h0000_0000, second_src_reg};
    assign acc      = {upper_acc_r, bottom_acc_r};

    ics_divider u_div (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .start     (div_start),
        .is_signed (op == OP_QUOT_S),
        .dividend  (base_src_reg),
        .divisor   (second_src_reg),
        .done      (div_done),
        .quot      (div_quot),
        .rem       (div_rem)
    );

    // Next-state logic of every execute-stage register.
    always_comb begin
        busy_nxt         = (busy_r & ~div_done);
        wb_en_nxt        = 1'b0;
        wb_idx_nxt       = wb_idx_r;
        wb_data_nxt      = wb_data_r;
        redirect_nxt     = 1'b0;
        target_nxt       = target_r;
        annul_nxt        = accept ? 1'b0 : annul_r;
        link_flag_nxt    = link_flag_r;
        link_address_nxt = link_address_r;
        debug_mode_nxt   = debug_mode_r;
        status_clr_nxt   = 1'b0;
        warmup_nxt       = 1'b0;
        warmup_addr_nxt  = warmup_addr_r;
        sys_wr_nxt       = 1'b0;
        sys_num_nxt      = sys_num_r;
        sys_sel_nxt      = sys_sel_r;
        sys_wdata_nxt    = sys_wdata_r;
        acc_new          = acc;
        div_start        = 1'b0;
        if (accept && !annul_r) begin
            unique case (op)
                OP_BR_NEG, OP_BR_NEG_LK, OP_BR_UNEQ, OP_BR_UNEQ_LK,
                OP_BR_NEG_SAVE, OP_BR_NEG_SV_LK: begin
                    redirect_nxt = take;
                    target_nxt   = br_tgt;
                    annul_nxt    = is_likely(op) & ~take;
                    if ((op == OP_BR_NEG_SAVE) || (op == OP_BR_NEG_SV_LK)) begin
                        wb_en_nxt   = 1'b1;
                        wb_idx_nxt  = `ICS_LINK_GPR;
                        wb_data_nxt = link_pc;
                    end
                end
                OP_REGION_JUMP, OP_REGION_JSAVE: begin
                    redirect_nxt = 1'b1;
                    target_nxt   = {pc[`ICS_REGION_HI:`ICS_REGION_LO], region_idx, 2'b00};
                    wb_en_nxt    = (op == OP_REGION_JSAVE);
                    wb_idx_nxt   = `ICS_LINK_GPR;
                    wb_data_nxt  = link_pc;
                end
                OP_JUMP_REG, OP_JUMP_SAVE_REG: begin
                    redirect_nxt = 1'b1;
                    target_nxt   = base_src_reg;
                    wb_en_nxt    = (op == OP_JUMP_SAVE_REG);
                    wb_idx_nxt   = dest_idx;
                    wb_data_nxt  = link_pc;
                end
                OP_DBG_RETURN: begin
                    redirect_nxt   = 1'b1;
                    target_nxt     = debug_return_pc;
                    debug_mode_nxt = 1'b0;
                end
                OP_EXC_RETURN: begin
                    redirect_nxt   = 1'b1;
                    target_nxt     = status_word[`ICS_ERR_LVL_BIT] ? error_return_pc : exc_return_pc;
                    status_clr_nxt = 1'b1;
                    link_flag_nxt  = 1'b0;
                end
                OP_QUOT_S, OP_QUOT_U: begin
                    div_start = 1'b1;
                    busy_nxt  = 1'b1;
                end
                OP_LD_BYTE, OP_LD_UBYTE, OP_LD_HALF, OP_LD_UHALF, OP_LD_WORD, OP_LD_LINKED: begin
                    wb_en_nxt   = 1'b1;
                    wb_idx_nxt  = second_idx;
                    wb_data_nxt = ld_ext(op, ld_data, eff_addr[1:0]);
                    if (op == OP_LD_LINKED) begin
                        link_flag_nxt    = 1'b1;
                        link_address_nxt = eff_addr;
                    end
                end
                OP_LD_UPPER: begin
                    wb_en_nxt   = 1'b1;
                    wb_idx_nxt  = second_idx;
                    wb_data_nxt = {imm16, 16'h0000};
                end
                OP_MAC_S:      acc_new = acc + prod_s;
                OP_MAC_U:      acc_new = acc + prod_u;
                OP_MDED_S:     acc_new = acc - prod_s;
                OP_MDED_U:     acc_new = acc - prod_u;
                OP_PROD_ACC_S: acc_new = prod_s;
                OP_PROD_ACC_U: acc_new = prod_u;
                OP_PROD_REG: begin
                    wb_en_nxt   = 1'b1;
                    wb_idx_nxt  = dest_idx;
                    wb_data_nxt = prod_s[31:0];
                end
                OP_MOVE_NZ, OP_MOVE_Z: begin
                    wb_en_nxt   = (second_src_reg == `ICS_WORD_RST) ^ (op == OP_MOVE_NZ);
                    wb_idx_nxt  = dest_idx;
                    wb_data_nxt = base_src_reg;
                end
                OP_LOGIC_OR, OP_NOT_OR: begin
                    wb_en_nxt   = 1'b1;
                    wb_idx_nxt  = dest_idx;
                    wb_data_nxt = (op == OP_NOT_OR) ? ~(base_src_reg | second_src_reg)
                                                    : (base_src_reg | second_src_reg);
                end
                OP_OR_IMM: begin
                    wb_en_nxt   = 1'b1;
                    wb_idx_nxt  = second_idx;
                    wb_data_nxt = base_src_reg | {16'h0000, imm16};
                end
                OP_WARMUP: begin
                    warmup_nxt      = 1'b1;
                    warmup_addr_nxt = eff_addr;
                end
                OP_SYS_WRITE: begin
                    sys_wr_nxt    = 1'b1;
                    sys_num_nxt   = sys_num;
                    sys_sel_nxt   = sys_sel;
                    sys_wdata_nxt = second_src_reg;
                end
                OP_SYS_READ: begin
                    wb_en_nxt   = 1'b1;
                    wb_idx_nxt  = second_idx;
                    wb_data_nxt = sys_rdata;
                end
                default: begin
                end
            endcase
        end
        if (div_done) begin
            acc_new = {div_rem, div_quot};
        end
        // Debug entry wins over a debug return in the same cycle.
        if (debug_enter) begin
            debug_mode_nxt = 1'b1;
        end
        upper_acc_nxt  = acc_new[63:32];
        bottom_acc_nxt = acc_new[31:0];
    end

    // Execute-stage registers; every output comes from here.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            busy_r         <= 1'b0;
            wb_en_r        <= 1'b0;
            wb_idx_r       <= `ICS_IDX_RST;
            wb_data_r      <= `ICS_WORD_RST;
            redirect_r     <= 1'b0;
            target_r       <= `ICS_WORD_RST;
            annul_r        <= 1'b0;
            upper_acc_r    <= `ICS_WORD_RST;
            bottom_acc_r   <= `ICS_WORD_RST;
            link_flag_r    <= 1'b0;
            link_address_r <= `ICS_WORD_RST;
            debug_mode_r   <= 1'b0;
            status_clr_r   <= 1'b0;
            warmup_r       <= 1'b0;
            warmup_addr_r  <= `ICS_WORD_RST;
            sys_wr_r       <= 1'b0;
            sys_num_r      <= `ICS_IDX_RST;
            sys_sel_r      <= `ICS_SEL_RST;
            sys_wdata_r    <= `ICS_WORD_RST;
        end else begin
            busy_r         <= busy_nxt;
            wb_en_r        <= wb_en_nxt;
            wb_idx_r       <= wb_idx_nxt;
            wb_data_r      <= wb_data_nxt;
            redirect_r     <= redirect_nxt;
            target_r       <= target_nxt;
            annul_r        <= annul_nxt;
            upper_acc_r    <= upper_acc_nxt;
            bottom_acc_r   <= bottom_acc_nxt;
            link_flag_r    <= link_flag_nxt;
            link_address_r <= link_address_nxt;
            debug_mode_r   <= debug_mode_nxt;
            status_clr_r   <= status_clr_nxt;
            warmup_r       <= warmup_nxt;
            warmup_addr_r  <= warmup_addr_nxt;
            sys_wr_r       <= sys_wr_nxt;
            sys_num_r      <= sys_num_nxt;
            sys_sel_r      <= sys_sel_nxt;
            sys_wdata_r    <= sys_wdata_nxt;
        end
    end

    // Checks that tie each result to the instruction that caused it.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic live;
    assign live = accept & ~annul_r;

    sequence s_div_go;
        live && ((op == OP_QUOT_S) || (op == OP_QUOT_U));
    endsequence

    sequence s_div_end;
        busy_r [*8] ##[1:30] !busy_r;
    endsequence

    property p_neg_branch;
        live && op == OP_BR_NEG |=> redirect_r == $past(base_src_reg[31]) && target_r == $past(br_tgt);
    endproperty
    a_neg_branch: assert property (p_neg_branch) else $error("negative branch wrong");

    property p_save_link;
        live && op == OP_BR_NEG_SAVE |=> wb_en_r && wb_idx_r == 5'h1F && wb_data_r == $past(pc) + 32'h8;
    endproperty
    a_save_link: assert property (p_save_link) else $error("save branch link wrong");

    property p_likely;
        live && is_likely(op) && !take |=> annul_r && !redirect_r ##1 !wb_en_r;
    endproperty
    a_likely: assert property (p_likely) else $error("likely branch did not annul");

    property p_unequal;
        live && op == OP_BR_UNEQ |=> redirect_r == ($past(base_src_reg) != $past(second_src_reg));
    endproperty
    a_unequal: assert property (p_unequal) else $error("unequal branch wrong");

    property p_dbg_ret;
        live && op == OP_DBG_RETURN && !debug_enter |=> !debug_mode_r && target_r == $past(debug_return_pc);
    endproperty
    a_dbg_ret: assert property (p_dbg_ret) else $error("debug return wrong");

    property p_div;
        s_div_go |=> s_div_end;
    endproperty
    a_div: assert property (p_div) else $error("divide did not finish in time");

    property p_div_val;
        live && op == OP_QUOT_U && second_src_reg == 32'h2 && base_src_reg == 32'h7
            |-> ##34 bottom_acc_r == 32'h3 && upper_acc_r == 32'h1;
    endproperty
    a_div_val: assert property (p_div_val) else $error("unsigned divide result wrong");

    property p_exc_ret;
        live && op == OP_EXC_RETURN |=> status_clr_r && !link_flag_r && redirect_r
            && target_r == ($past(status_word[2]) ? $past(error_return_pc) : $past(exc_return_pc));
    endproperty
    a_exc_ret: assert property (p_exc_ret) else $error("exception return wrong");

    property p_upper;
        live && op == OP_LD_UPPER |=> wb_data_r == {$past(imm16), 16'h0000} && wb_idx_r == $past(second_idx);
    endproperty
    a_upper: assert property (p_upper) else $error("upper constant wrong");

    property p_mac;
        live && op == OP_MAC_S |=> {upper_acc_r, bottom_acc_r} == $past(acc) + $past(prod_s);
    endproperty
    a_mac: assert property (p_mac) else $error("accumulate wrong");

    property p_annul;
        annul_r && accept |=> !wb_en_r && !redirect_r && !sys_wr_r;
    endproperty
    a_annul: assert property (p_annul) else $error("annulled slot had effect");

endmodule

// ==== logic/ics_regs.svh ====
// Constants for the integer core execute unit: offsets, bit positions, reset values and counts.
`ifndef ICS_REGS_SVH
`define ICS_REGS_SVH

`define ICS_LINK_GPR      5'h1F
`define ICS_LINK_OFS      32'h0000_0008
`define ICS_SEQ_OFS       32'h0000_0004
`define ICS_UPPER_SHIFT   16
`define ICS_ERR_LVL_BIT   2
`define ICS_REGION_HI     31
`define ICS_REGION_LO     28
`define ICS_WORD_RST      32'h0000_0000
`define ICS_IDX_RST       5'h00
`define ICS_SEL_RST       3'h0
`define ICS_DIV_STEPS     6'h20

`endif

// ==== logic/ics_pkg.sv ====
// Types shared by the integer core execute unit.
package ics_pkg;

    typedef logic [31:0] ics_word_t;

    // Operations handed over by the decode stage.
    typedef enum logic [5:0] {
        OP_NONE          = 6'b000000,
        OP_BR_NEG        = 6'b000001,
        OP_BR_NEG_SAVE   = 6'b000010,
        OP_BR_NEG_SV_LK  = 6'b000011,
        OP_BR_NEG_LK     = 6'b000100,
        OP_BR_UNEQ       = 6'b000101,
        OP_BR_UNEQ_LK    = 6'b000110,
        OP_DBG_RETURN    = 6'b000111,
        OP_QUOT_S        = 6'b001000,
        OP_QUOT_U        = 6'b001001,
        OP_EXC_RETURN    = 6'b001010,
        OP_REGION_JUMP   = 6'b001011,
        OP_REGION_JSAVE  = 6'b001100,
        OP_JUMP_SAVE_REG = 6'b001101,
        OP_JUMP_REG      = 6'b001110,
        OP_LD_BYTE       = 6'b001111,
        OP_LD_UBYTE      = 6'b010000,
        OP_LD_HALF       = 6'b010001,
        OP_LD_UHALF      = 6'b010010,
        OP_LD_WORD       = 6'b010011,
        OP_LD_LINKED     = 6'b010100,
        OP_LD_UPPER      = 6'b010101,
        OP_MAC_S         = 6'b010110,
        OP_MAC_U         = 6'b010111,
        OP_MDED_S        = 6'b011000,
        OP_MDED_U        = 6'b011001,
        OP_SYS_READ      = 6'b011010,
        OP_SYS_WRITE     = 6'b011011,
        OP_MOVE_NZ       = 6'b011100,
        OP_MOVE_Z        = 6'b011101,
        OP_PROD_REG      = 6'b011110,
        OP_PROD_ACC_S    = 6'b011111,
        OP_PROD_ACC_U    = 6'b100000,
        OP_NOT_OR        = 6'b100001,
        OP_LOGIC_OR      = 6'b100010,
        OP_OR_IMM        = 6'b100011,
        OP_WARMUP        = 6'b100100
    } ics_op_e;

endpackage

// ==== logic/ics_divider.sv ====
// Iterative restoring divider for signed and unsigned quotient and remainder.
`timescale 1ns/1ns
`include "ics_regs.svh"

module ics_divider (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              start,
    input  wire logic              is_signed,
    input  wire ics_pkg::ics_word_t dividend,
    input  wire ics_pkg::ics_word_t divisor,
    output logic                   done,
    output ics_pkg::ics_word_t     quot,
    output ics_pkg::ics_word_t     rem
);
    import ics_pkg::*;

    logic [5:0]  cnt_r, cnt_nxt;
    logic        run_r, run_nxt;
    logic        done_r, done_nxt;
    logic        qneg_r, qneg_nxt;
    logic        rneg_r, rneg_nxt;
    ics_word_t   q_r, q_nxt;
    ics_word_t   r_r, r_nxt;
    ics_word_t   d_r, d_nxt;
    logic [32:0] trial;

    // One quotient bit per cycle; signs are stripped at start and restored at the end.
    always_comb begin
        cnt_nxt  = cnt_r;
        run_nxt  = run_r;
        done_nxt = 1'b0;
        qneg_nxt = qneg_r;
        rneg_nxt = rneg_r;
        q_nxt    = q_r;
        r_nxt    = r_r;
        d_nxt    = d_r;
        trial    = {r_r, q_r[31]} - {1'b0, d_r};
        if (start) begin
            run_nxt  = 1'b1;
            cnt_nxt  = `ICS_DIV_STEPS;
            rneg_nxt = is_signed & dividend[31];
            qneg_nxt = is_signed & (dividend[31] ^ divisor[31]) & (divisor != `ICS_WORD_RST);
            q_nxt    = (is_signed & dividend[31]) ? -dividend : dividend;
            d_nxt    = (is_signed & divisor[31]) ? -divisor : divisor;
            r_nxt    = `ICS_WORD_RST;
        end else if (run_r) begin
            if (trial[32]) begin
                r_nxt = {r_r[30:0], q_r[31]};
                q_nxt = {q_r[30:0], 1'b0};
            end else begin
                r_nxt = trial[31:0];
                q_nxt = {q_r[30:0], 1'b1};
            end
            cnt_nxt = cnt_r - 6'h01;
            if (cnt_r == 6'h01) begin
                run_nxt  = 1'b0;
                done_nxt = 1'b1;
            end
        end
    end

    // Divider state registers.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_r  <= 6'h00;
            run_r  <= 1'b0;
            done_r <= 1'b0;
            qneg_r <= 1'b0;
            rneg_r <= 1'b0;
            q_r    <= `ICS_WORD_RST;
            r_r    <= `ICS_WORD_RST;
            d_r    <= `ICS_WORD_RST;
        end else begin
            cnt_r  <= cnt_nxt;
            run_r  <= run_nxt;
            done_r <= done_nxt;
            qneg_r <= qneg_nxt;
            rneg_r <= rneg_nxt;
            q_r    <= q_nxt;
            r_r    <= r_nxt;
            d_r    <= d_nxt;
        end
    end

    // Results are valid while done is high.
    assign done = done_r;
    assign quot = qneg_r ? -q_r : q_r;
    assign rem  = rneg_r ? -r_r : r_r;

endmodule

// ==== verification/tb_integer_core_instr_semantics.sv ====
// Self-checking testbench for the integer core execute stage.
`timescale 1ns/1ns
module tb_integer_core_instr_semantics;
    import ics_pkg::*;
    logic        ref_clk, rst, issue_valid, debug_enter;
    ics_op_e     op;
    ics_word_t   pc, base_src_reg, second_src_reg, sys_rdata, ld_data, status_word;
    ics_word_t   exc_return_pc, error_return_pc, debug_return_pc;
    logic [4:0]  dest_idx, second_idx, sys_num, wb_idx_r, sys_num_r;
    logic [2:0]  sys_sel, sys_sel_r;
    logic [15:0] imm16;
    logic [25:0] region_idx;
    logic        busy_r, wb_en_r, redirect_r, annul_r, link_flag_r, debug_mode_r, status_clr_r, warmup_r, sys_wr_r;
    ics_word_t   wb_data_r, target_r, upper_acc_r, bottom_acc_r, link_address_r, warmup_addr_r, sys_wdata_r;
    int          err_count = 0;
    int          n_compared = 0;
    int          cyc = 0;

    ics_exec dut (.*);

    // Clock of 100 ns period.
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // Cuts a hang short once the cycle ceiling is reached.
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            err_count++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("Mismatches %0d, comparisons %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Holds one operation for one edge; the registered results are settled on return.
    task automatic issue(input ics_op_e o, input ics_word_t a, input ics_word_t b);
        @(posedge ref_clk);
        #1;
        issue_valid = 1'b1;
        op = o;
        base_src_reg = a;
        second_src_reg = b;
        @(posedge ref_clk);
        #1;
        issue_valid = 1'b0;
    endtask

    task automatic test_branches();
        pc = 32'h0000_1000;
        imm16 = 16'hFFFF;
        issue(OP_BR_NEG, 32'h7FFF_FFFF, 32'h0);
        chk(redirect_r, 1'b0);
        issue(OP_BR_NEG_SAVE, 32'h8000_0000, 32'h0);
        chk({redirect_r, target_r}, {1'b1, 32'h0000_1000});
        chk({wb_en_r, wb_idx_r, wb_data_r}, {1'b1, 5'h1F, 32'h0000_1008});
        issue(OP_BR_UNEQ_LK, 32'h5, 32'h5);
        chk({annul_r, redirect_r}, 2'b10);
        second_idx = 5'h03;
        imm16 = 16'h1234;
        issue(OP_LD_UPPER, 32'h0, 32'h0);
        chk({annul_r, wb_en_r}, 2'b00);
        issue(OP_LD_UPPER, 32'h0, 32'h0);
        chk({wb_en_r, wb_idx_r, wb_data_r}, {1'b1, 5'h03, 32'h1234_0000});
    endtask

    task automatic test_divide(input ics_op_e o, input ics_word_t a, input ics_word_t b, input logic [63:0] exp);
        issue(o, a, b);
        chk(busy_r, 1'b1);
        for (int i = 0; i < 40 && busy_r !== 1'b0; i++) begin
            @(posedge ref_clk);
            #1;
        end
        chk({upper_acc_r, bottom_acc_r}, exp);
    endtask

    task automatic test_multiply();
        issue(OP_PROD_ACC_S, 32'hFFFF_FFFE, 32'h3);
        chk({upper_acc_r, bottom_acc_r}, 64'hFFFF_FFFF_FFFF_FFFA);
        issue(OP_MAC_U, 32'hFFFF_FFFF, 32'h2);
        chk({upper_acc_r, bottom_acc_r}, 64'h0000_0001_FFFF_FFF8);
        issue(OP_MDED_S, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
        chk({upper_acc_r, bottom_acc_r}, 64'h0000_0001_FFFF_FFF7);
        issue(OP_MAC_S, 32'hFFFF_FFFF, 32'h2);
        chk({upper_acc_r, bottom_acc_r}, 64'h0000_0001_FFFF_FFF5);
        dest_idx = 5'h09;
        issue(OP_PROD_REG, 32'hFFFF_FFFE, 32'h3);
        chk({wb_idx_r, wb_data_r}, {5'h09, 32'hFFFF_FFFA});
    endtask

    task automatic test_link_return();
        imm16 = 16'h0010;
        ld_data = 32'hCAFE_0001;
        issue(OP_LD_LINKED, 32'h0000_0100, 32'h0);
        chk({link_flag_r, link_address_r, wb_data_r}, {1'b1, 32'h0000_0110, 32'hCAFE_0001});
        status_word = 32'h0000_0004;
        error_return_pc = 32'h0000_2000;
        issue(OP_EXC_RETURN, 32'h0, 32'h0);
        chk({link_flag_r, status_clr_r, redirect_r, target_r}, {3'b011, 32'h0000_2000});
    endtask

    task automatic test_jumps();
        pc = 32'hA000_0100;
        dest_idx = 5'h05;
        region_idx = 26'h400;
        issue(OP_REGION_JSAVE, 32'h0, 32'h0);
        chk({redirect_r, target_r, wb_en_r, wb_idx_r}, {1'b1, 32'hA000_1000, 1'b1, 5'h1F});
        issue(OP_JUMP_SAVE_REG, 32'h3000, 32'h0);
        chk({target_r, wb_en_r, wb_idx_r, wb_data_r}, {32'h3000, 1'b1, 5'h05, 32'hA000_0108});
        issue(OP_JUMP_REG, 32'h4000, 32'h0);
        chk({redirect_r, target_r, wb_en_r}, {1'b1, 32'h4000, 1'b0});
        issue(OP_BR_UNEQ, 32'h1, 32'h2);
        chk({redirect_r, target_r}, {1'b1, 32'hA000_0144});
        debug_enter = 1'b1;
        debug_return_pc = 32'h0BF0;
        issue(OP_NONE, 32'h0, 32'h0);
        debug_enter = 1'b0;
        chk(debug_mode_r, 1'b1);
        issue(OP_DBG_RETURN, 32'h0, 32'h0);
        chk({debug_mode_r, redirect_r, target_r}, {2'b01, 32'h0BF0});
    endtask

    task automatic test_data();
        imm16 = 16'h0001;
        ld_data = 32'h8077_F180;
        issue(OP_LD_BYTE, 32'h100, 32'h0);
        chk({wb_idx_r, wb_data_r}, {5'h03, 32'hFFFF_FFF1});
        issue(OP_LD_UHALF, 32'h101, 32'h0);
        chk(wb_data_r, 32'h8077);
        issue(OP_WARMUP, 32'h100, 32'h0);
        chk({warmup_r, warmup_addr_r}, {1'b1, 32'h101});
        issue(OP_OR_IMM, 32'hF000, 32'h0);
        chk(wb_data_r, 32'hF001);
        issue(OP_NOT_OR, 32'hF0, 32'h0F);
        chk({wb_idx_r, wb_data_r}, {5'h05, 32'hFFFF_FF00});
        issue(OP_MOVE_NZ, 32'h55, 32'h1);
        chk({wb_en_r, wb_data_r}, {1'b1, 32'h55});
        sys_num = 5'h0C;
        sys_sel = 3'h2;
        sys_rdata = 32'hD001;
        issue(OP_SYS_WRITE, 32'h0, 32'h1234_5678);
        chk({sys_wr_r, sys_num_r, sys_sel_r, sys_wdata_r}, {1'b1, 5'h0C, 3'h2, 32'h1234_5678});
        issue(OP_SYS_READ, 32'h0, 32'h0);
        chk({wb_en_r, wb_idx_r, wb_data_r}, {1'b1, 5'h03, 32'hD001});
    endtask

    // Resets, then runs each scenario in turn.
    initial begin
        {issue_valid, debug_enter, pc, base_src_reg, second_src_reg, sys_rdata, ld_data, status_word} = '0;
        {exc_return_pc, error_return_pc, debug_return_pc, dest_idx, second_idx, sys_num, sys_sel, imm16, region_idx} = '0;
        op = OP_NONE;
        rst = 1'b1;
        repeat (8) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        test_branches();
        test_divide(OP_QUOT_U, 32'h7, 32'h2, {32'h1, 32'h3});
        test_divide(OP_QUOT_S, 32'hFFFF_FFF9, 32'h2, {32'hFFFF_FFFF, 32'hFFFF_FFFD});
        test_multiply();
        test_link_return();
        test_jumps();
        test_data();
        report_and_stop();
    end
endmodule
